// >>> sas_seq.sv
// sas_seq: sequencer, channel latch and result register of an 8-bit
// successive-approximation converter with an 8-way input multiplexer
// assumes every pin input except RESETN is asynchronous to MCLK; the analog front end
// (mux switches, sampling switch, dac, comparator) sits outside
//
// Behaviour
// - select latched on rising latch strobe edge
// - select value picks channel zero to seven
// - successive approximation register holds bit decisions
// - rising start resets conversion registers
// - sequence counts from first edge after start falls
// - sampling from edge four to edge eight
// - done output falls on eighth edge
// - seven ticks per bit, fifty-six total
// - result loaded, done rises at edge 67
// - old result stays until next done rise
// - new start aborts and restarts conversion
// - comparator auto-zeroed before bit decisions
// - start held high keeps sequencer reset
// - output enable low floats result bus
`timescale 1ns/1ps
`default_nettype none

module sas_seq #(
	parameter logic [7:0] CLK_DIV = 8'h01
) (
	// clock and reset
	input wire logic MCLK,
	input wire logic RESETN,
	// host side
	input wire logic [2:0] CHANNEL_SELECT,
	input wire logic ADDR_LATCH,
	input wire logic START,
	input wire logic OE,
	output logic EOC,
	output logic [7:0] RESULT_BUS_O,
	output logic [7:0] RESULT_BUS_OE_N,
	// analog front end
	input wire logic COMP_IN,
	output sas_pkg::sas_analog_t ANALOG_CTRL
);

	function automatic logic [7:0] sas_onehot(input logic [2:0] code);
		sas_onehot = 8'h01 << code;
	endfunction

	sas_pkg::sas_state_t st;
	sas_pkg::sas_state_t next_st;
	logic tick;
	logic [6:0] next_cnt;

	// converter clock enable; a slower rate widens the sampling window
	assign tick = (st.div == CLK_DIV - 8'h01);
	assign next_cnt = st.cnt + 7'h01;

	always_comb begin
		next_st = st;
		next_st.sel_s1 = CHANNEL_SELECT;
		next_st.sel_s2 = st.sel_s1;
		next_st.ale_s1 = ADDR_LATCH;
		next_st.ale_s2 = st.ale_s1;
		next_st.ale_s3 = st.ale_s2;
		next_st.start_s1 = START;
		next_st.start_s2 = st.start_s1;
		next_st.start_s3 = st.start_s2;
		next_st.oe_s1 = OE;
		next_st.oe_s2 = st.oe_s1;
		next_st.comp_s1 = COMP_IN;
		next_st.comp_s2 = st.comp_s1;

		if (st.ale_s2 && !st.ale_s3) begin
			next_st.sel = st.sel_s2;
		end

		// mux follows the latch until sampling closes
		if (!(st.run && st.cnt >= sas_pkg::SAMPLE_CLOSE)) begin
			next_st.chan_en = sas_onehot(st.sel);
		end

		if (st.start_s2) begin
			// held here while start is high; counting begins after it falls
			next_st.run = 1'h1;
			next_st.cnt = 7'h00;
			next_st.div = 8'h00;
			next_st.slot = 3'h0;
			next_st.sar = 8'h00;
			next_st.mask = 8'h00;
			next_st.sample = 1'h0;
			next_st.auto_zero = 1'h1;
		end else if (st.run) begin
			next_st.div = tick ? 8'h00 : st.div + 8'h01;
			if (tick) begin
				next_st.cnt = next_cnt;
				next_st.slot = (st.slot == sas_pkg::BIT_TICKS - 3'h1) ? 3'h0 : st.slot + 3'h1;
				if (next_cnt == sas_pkg::SAMPLE_OPEN) begin
					next_st.auto_zero = 1'h0;
					next_st.sample = 1'h1;
				end
				if (next_cnt == sas_pkg::SAMPLE_CLOSE) begin
					next_st.sample = 1'h0;
					next_st.eoc = 1'h0;
					next_st.sar = sas_pkg::SAR_FIRST;
					next_st.mask = sas_pkg::SAR_FIRST;
					next_st.slot = 3'h0;
				end else if (st.mask != 8'h00 && st.slot == sas_pkg::BIT_TICKS - 3'h1) begin
					// keep the trial bit when the comparator says input is above
					next_st.sar = (st.comp_s2 ? st.sar : (st.sar & ~st.mask)) | (st.mask >> 1);
					next_st.mask = st.mask >> 1;
				end
				if (next_cnt == sas_pkg::DONE_EDGE) begin
					next_st.result = st.sar;
					next_st.eoc = 1'h1;
					next_st.run = 1'h0;
				end
			end
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RESETN) begin
			st <= sas_pkg::STATE_RST;
		end else begin
			st <= next_st;
		end
	end

	assign EOC = st.eoc;
	assign RESULT_BUS_O = st.result;
	assign RESULT_BUS_OE_N = {8{~st.oe_s2}};
	assign ANALOG_CTRL.chan_en = st.chan_en;
	assign ANALOG_CTRL.sample = st.sample;
	assign ANALOG_CTRL.auto_zero = st.auto_zero;
	assign ANALOG_CTRL.dac_code = st.sar;

	// checks
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RESETN);

	latch_capture_a: assert property (
		(st.ale_s2 && !st.ale_s3) |=> (st.sel == $past(st.sel_s2)))
		else $error("select latch did not capture on strobe edge");

	latch_hold_a: assert property (
		!(st.ale_s2 && !st.ale_s3) |=> $stable(st.sel))
		else $error("select latch changed without strobe edge");

	chan_decode_a: assert property (
		!(st.run && st.cnt >= sas_pkg::SAMPLE_CLOSE) && !$past(st.run && st.cnt >= sas_pkg::SAMPLE_CLOSE)
		|-> ANALOG_CTRL.chan_en == sas_onehot($past(st.sel)))
		else $error("channel enable does not match latched select");

	start_hold_a: assert property (
		st.start_s2 |=> (st.cnt == 7'h00 && st.run && !ANALOG_CTRL.sample))
		else $error("sequencer not held while start high");

	seq_restart_a: assert property (
		$fell(st.start_s2) && CLK_DIV == 8'h01 |-> ##1 (st.cnt == 7'h01) ##3 (st.cnt == 7'h04 && ANALOG_CTRL.sample))
		else $error("sequence did not restart after start fell");

	sample_open_a: assert property (
		$rose(ANALOG_CTRL.sample) |-> (st.cnt == sas_pkg::SAMPLE_OPEN))
		else $error("sampling opened at wrong edge");

	sample_close_a: assert property (
		$fell(ANALOG_CTRL.sample) && !$past(st.start_s2) |-> (st.cnt == sas_pkg::SAMPLE_CLOSE && !EOC))
		else $error("sampling closed at wrong edge");

	eoc_fall_a: assert property (
		$fell(EOC) |-> (st.cnt == sas_pkg::SAMPLE_CLOSE && ANALOG_CTRL.dac_code == sas_pkg::SAR_FIRST))
		else $error("done fell at wrong edge");

	bit_slot_a: assert property (
		$changed(st.mask) && st.mask != sas_pkg::SAR_FIRST && !$past(st.start_s2)
		|-> (st.cnt > sas_pkg::SAMPLE_CLOSE && st.cnt <= sas_pkg::DECIDE_LAST
		&& (st.cnt - sas_pkg::SAMPLE_CLOSE) % 7'h07 == 7'h00))
		else $error("bit decision off its seven tick slot");

	msb_first_a: assert property (
		$changed(st.mask) && st.mask != 8'h00 && $past(st.mask) != 8'h00 |-> (st.mask == ($past(st.mask) >> 1)))
		else $error("bits not resolved msb first");

	eoc_rise_a: assert property (
		$rose(EOC) |-> (st.cnt == sas_pkg::DONE_EDGE && RESULT_BUS_O == $past(st.sar)))
		else $error("done rose at wrong edge or wrong data");

	result_hold_a: assert property (
		$changed(RESULT_BUS_O) |-> $rose(EOC))
		else $error("result changed outside done rise");

	autozero_a: assert property (
		ANALOG_CTRL.auto_zero |-> (st.run && st.cnt < sas_pkg::SAMPLE_OPEN))
		else $error("auto-zero outside conversion start");

	chan_freeze_a: assert property (
		st.run && st.cnt >= sas_pkg::SAMPLE_CLOSE && !st.start_s2 |=> $stable(ANALOG_CTRL.chan_en))
		else $error("channel changed after sampling");

	oe_drive_a: assert property (
		OE ##1 OE |-> ##1 (RESULT_BUS_OE_N == 8'h00))
		else $error("result bus not driven with output enable");

	oe_off_a: assert property (
		!OE ##1 !OE |-> ##1 (RESULT_BUS_OE_N == 8'hFF))
		else $error("result bus not floated without output enable");

	// sequence shape: done low span, window length, decision bookkeeping

	eoc_low_a: assert property (
		st.run && st.cnt >= sas_pkg::SAMPLE_CLOSE && st.cnt < sas_pkg::DONE_EDGE |-> !EOC)
		else $error("done high during bit decisions");

	sample_len_a: assert property (disable iff (!RESETN || st.start_s2)
		$rose(ANALOG_CTRL.sample) && CLK_DIV == 8'h01 |-> ANALOG_CTRL.sample [*4] ##1 !ANALOG_CTRL.sample)
		else $error("sampling window not four ticks long");

	decide_done_a: assert property (
		$rose(EOC) |-> (st.mask == 8'h00 && !st.run))
		else $error("done rose before all bits decided");

	cnt_bound_a: assert property (
		st.cnt <= sas_pkg::DONE_EDGE)
		else $error("tick count ran past the done edge");

	slot_range_a: assert property (
		st.slot < sas_pkg::BIT_TICKS)
		else $error("bit slot counter out of range");

	run_idle_a: assert property (
		!st.run |-> EOC)
		else $error("done low while sequencer idle");

	mask_onehot_a: assert property (
		$onehot0(st.mask))
		else $error("trial bit mask not one-hot");

	chan_onehot_a: assert property (
		$onehot(ANALOG_CTRL.chan_en))
		else $error("channel enable not one-hot");

	sample_zero_a: assert property (
		!(ANALOG_CTRL.sample && ANALOG_CTRL.auto_zero))
		else $error("auto-zero overlaps sampling");

	sar_clear_a: assert property (
		st.start_s2 |=> (ANALOG_CTRL.dac_code == 8'h00 && st.mask == 8'h00))
		else $error("start did not clear approximation register");

	eoc_keep_a: assert property (
		st.start_s2 |=> $stable(EOC))
		else $error("start changed done output");

	result_idle_a: assert property (
		$changed(RESULT_BUS_O) |-> !st.run)
		else $error("result changed while converting");

	oe_bits_a: assert property (
		RESULT_BUS_OE_N == {8{RESULT_BUS_OE_N[0]}})
		else $error("result bus enables disagree");

	// scenarios worth seeing

	done_c: cover property (
		$fell(st.start_s2) ##[1:300] $rose(EOC));

	abort_c: cover property (
		!EOC && st.run && st.cnt > sas_pkg::SAMPLE_CLOSE ##1 st.start_s2);

	latch_mid_c: cover property (
		(st.ale_s2 && !st.ale_s3) && st.run && st.cnt > sas_pkg::SAMPLE_CLOSE);

	full_code_c: cover property (
		$rose(EOC) && RESULT_BUS_O == 8'hFF);

endmodule // sas_seq

`default_nettype wire

// >>> sas_pkg.sv
// sas_pkg: constants and types for the converter sequencer
// assumes one clock at 100 MHz; all counts are in converter clock ticks
package sas_pkg;

	localparam int NBITS = 8;
	localparam int NCHAN = 8;

	// sequence edges, counted in converter clock ticks after start falls
	localparam logic [6:0] SAMPLE_OPEN = 7'h04;
	localparam logic [6:0] SAMPLE_CLOSE = 7'h08;
	localparam logic [6:0] DONE_EDGE = 7'h43;
	localparam logic [6:0] DECIDE_LAST = 7'h40;
	localparam logic [2:0] BIT_TICKS = 3'h7;
	localparam logic [7:0] SAR_FIRST = 8'h80;
	localparam logic [7:0] RESULT_RST = 8'h00;
	localparam logic EOC_RST = 1'h1;

	// controls handed to the analog front end
	typedef struct packed {
		logic [7:0] chan_en;
		logic sample;
		logic auto_zero;
		logic [7:0] dac_code;
	} sas_analog_t;

	typedef struct packed {
		logic [2:0] sel_s1;
		logic [2:0] sel_s2;
		logic [2:0] sel;
		logic ale_s1;
		logic ale_s2;
		logic ale_s3;
		logic start_s1;
		logic start_s2;
		logic start_s3;
		logic oe_s1;
		logic oe_s2;
		logic comp_s1;
		logic comp_s2;
		logic run;
		logic [6:0] cnt;
		logic [7:0] div;
		logic [2:0] slot;
		logic [7:0] sar;
		logic [7:0] mask;
		logic [7:0] result;
		logic eoc;
		logic sample;
		logic auto_zero;
		logic [7:0] chan_en;
	} sas_state_t;

	localparam sas_state_t STATE_RST = '{
		sel_s1: 3'h0, sel_s2: 3'h0, sel: 3'h0,
		ale_s1: 1'h0, ale_s2: 1'h0, ale_s3: 1'h0,
		start_s1: 1'h0, start_s2: 1'h0, start_s3: 1'h0,
		oe_s1: 1'h0, oe_s2: 1'h0, comp_s1: 1'h0, comp_s2: 1'h0,
		run: 1'h0, cnt: 7'h00, div: 8'h00, slot: 3'h0,
		sar: 8'h00, mask: 8'h00, result: RESULT_RST, eoc: EOC_RST,
		sample: 1'h0, auto_zero: 1'h0, chan_en: 8'h01
	};

endpackage

// >>> sas_afe_model.sv
// sas_afe_model: analog front end seen by the sequencer
// assumes levels are static per channel; comparator answers without delay
`timescale 1ns/1ps
`default_nettype none

module sas_afe_model (
	// clock
	input wire logic MCLK,
	// sequencer side
	input wire sas_pkg::sas_analog_t ANALOG_CTRL,
	input wire logic [63:0] LEVELS,
	output logic COMP_IN
);
	logic [7:0] held = 8'h00;
	// track the enabled channel while the switch is closed
	always @(posedge MCLK) begin
		if (ANALOG_CTRL.sample) begin
			for (int i = 0; i < 8; i++) begin
				if (ANALOG_CTRL.chan_en[i]) held <= LEVELS[i*8 +: 8];
			end
		end
	end
	assign COMP_IN = held >= ANALOG_CTRL.dac_code;
endmodule // sas_afe_model

`default_nettype wire

// >>> test_sar_adc_sequencer_with_channel_select.sv
// test bench: conversions on every channel, abort, bus enable
// assumes CLK_DIV of one and the front end model beside the sequencer
`timescale 1ns/1ps
`default_nettype none

module test_sar_adc_sequencer_with_channel_select;
	logic MCLK = 0, RESETN = 0, ADDR_LATCH = 0, START = 0, OE = 0;
	logic [2:0] CHANNEL_SELECT = 3'h0;
	logic EOC, COMP_IN;
	logic [7:0] RESULT_BUS_O, RESULT_BUS_OE_N;
	sas_pkg::sas_analog_t ANALOG_CTRL;
	logic [63:0] LEVELS = 64'h0;
	logic [31:0] rnd = 32'hB6F6;
	logic [7:0] old = 8'h00;
	int mismatches = 0, checks_done = 0, cur = 0;
	// edges from the start fall being driven to done rising
	int lat = 69;

	initial forever #5 MCLK = ~MCLK;

	sas_seq #(.CLK_DIV(8'h01)) dut_u (
		.MCLK(MCLK), .RESETN(RESETN), .CHANNEL_SELECT(CHANNEL_SELECT), .ADDR_LATCH(ADDR_LATCH),
		.START(START), .OE(OE), .EOC(EOC), .RESULT_BUS_O(RESULT_BUS_O), .RESULT_BUS_OE_N(RESULT_BUS_OE_N),
		.COMP_IN(COMP_IN), .ANALOG_CTRL(ANALOG_CTRL));
	sas_afe_model afe_u (.MCLK(MCLK), .ANALOG_CTRL(ANALOG_CTRL), .LEVELS(LEVELS), .COMP_IN(COMP_IN));

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge MCLK);
	endtask

	task automatic pick(input int ch);
		tick(1);
		CHANNEL_SELECT <= 3'(ch);
		ADDR_LATCH <= 1'b1;
		tick(3);
		ADDR_LATCH <= 1'b0;
		tick(3);
		cur = ch;
	endtask

	// one start pulse, checked edge by edge; ab > 0 aborts at that edge
	task automatic conv(input int ab, input logic prev);
		logic [7:0] nxt;
		int ch;
		ch = cur;
		nxt = LEVELS[ch*8 +: 8];
		rnd = lfsr(rnd);
		tick(1);
		START <= 1'b1;
		tick(3);
		START <= 1'b0;
		for (int k = 1; k <= lat; k++) begin
			tick(1);
			if (k == 20) begin
				CHANNEL_SELECT <= rnd[2:0];
				ADDR_LATCH <= 1'b1;
				cur = int'(rnd[2:0]);
			end
			if (k == 23) ADDR_LATCH <= 1'b0;
			#1;
			check({7'h0, EOC}, (k < 10) ? prev : (k >= lat));
			check({7'h0, ANALOG_CTRL.sample}, k >= 6 && k < 10);
			check({7'h0, ANALOG_CTRL.auto_zero}, k < 6);
			check(RESULT_BUS_O, (k >= lat) ? nxt : old);
			if (k >= 11 && k < lat) check(ANALOG_CTRL.chan_en, 8'h01 << ch);
			if (k == ab) return;
		end
		old = nxt;
	endtask

	task automatic end_of_test;
		$display("mismatches %0d checks %0d", mismatches, checks_done);
		if (mismatches == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		#100000;
		mismatches++;
		end_of_test;
	end

	initial begin
		for (int i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			LEVELS[i*8 +: 8] <= rnd[7:0];
		end
		tick(16);
		#1;
		check(RESULT_BUS_O, 8'h00);
		check({7'h0, EOC}, 8'h01);
		check(RESULT_BUS_OE_N, 8'hFF);
		tick(1);
		RESETN <= 1'b1;
		tick(1);
		for (int c = 0; c < 8; c++) begin
			pick(c);
			conv(0, 1'b1);
		end
		conv(30, 1'b1);
		conv(0, 1'b0);
		tick(1);
		OE <= 1'b1;
		tick(3);
		#1;
		check(RESULT_BUS_OE_N, 8'h00);
		tick(1);
		OE <= 1'b0;
		tick(3);
		#1;
		check(RESULT_BUS_OE_N, 8'hFF);
		end_of_test;
	end
endmodule // test_sar_adc_sequencer_with_channel_select

`default_nettype wire
